// File: hw/pinirq_top.sv
// External pin interrupt unit: sixteen maskable lines and one non-maskable line.
// Assumes register writes arrive as core-clock strobes; pins are asynchronous.
module pinirq_top (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] EXT_LINE,
  input wire logic NONMASK_PIN,
  input wire logic SAMPLE_CLK,
  output logic SAMPLE_CLK_REQ,
  input wire logic CTRL_WR,
  input pinirq_pkg::pinirq_ctrl_t CTRL_WDATA,
  output pinirq_pkg::pinirq_ctrl_t CTRL_RD,
  output logic SYNC_BUSY,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] CFG_WR,
  input pinirq_pkg::pinirq_linecfg_t [pinirq_pkg::NUM_LINES-1:0] CFG_WDATA,
  output pinirq_pkg::pinirq_linecfg_t [pinirq_pkg::NUM_LINES-1:0] CFG_RD,
  input wire logic NONMASK_CTRL_WR,
  input pinirq_pkg::pinirq_linecfg_t NONMASK_CTRL_WDATA,
  output pinirq_pkg::pinirq_linecfg_t NONMASK_CTRL_RD,
  input wire logic EVENT_OUT_CTRL_WR,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] EVENT_OUT_CTRL_WDATA,
  output logic [pinirq_pkg::NUM_LINES-1:0] EVENT_OUT_CTRL_RD,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] IRQ_ENABLE_SET,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] IRQ_ENABLE_CLEAR,
  output logic [pinirq_pkg::NUM_LINES-1:0] IRQ_ENABLE_RD,
  input wire logic [pinirq_pkg::NUM_LINES-1:0] LINE_FLAG_CLR,
  output logic [pinirq_pkg::NUM_LINES-1:0] LINE_FLAG_RD,
  input wire logic NONMASK_FLAG_CLR,
  output logic NONMASK_FLAG_RD,
  input wire logic PROTECT_EN,
  input wire logic DEBUG_ACCESS,
  output logic [pinirq_pkg::NUM_LINES-1:0] LINE_IRQ,
  output logic NONMASK_IRQ,
  output logic [pinirq_pkg::NUM_LINES-1:0] LINE_EVENT
);

  localparam int NL = pinirq_pkg::NUM_LINES;

  pinirq_pkg::pinirq_state_t state_r;
  pinirq_pkg::pinirq_state_t state_nxt;
  logic [NL+1:0] pins_s;
  logic tick;
  logic [NL:0] det;
  logic [NL-1:0] det_g;
  logic wr_ok;
  logic ctrl_take;
  logic sync_done;
  pinirq_pkg::pinirq_linecfg_t [NL:0] line_cfg;

  // Pins and the sampling clock are foreign to the core clock
  pinirq_sync #(
    .WIDTH(NL + 2)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .din({SAMPLE_CLK, NONMASK_PIN, EXT_LINE}),
    .dout(pins_s)
  );

  assign tick = pins_s[NL+1] & ~state_r.tick_prev;
  assign line_cfg = {state_r.nmi_cfg, state_r.cfg};

  genvar gi;
  generate
    for (gi = 0; gi <= NL; gi++) begin : g_line
      pinirq_line u_line (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .pin(pins_s[gi]),
        .tick(tick),
        .cfg(line_cfg[gi]),
        .det(det[gi])
      );
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    // Debugger writes pass protection; flags are never protected
    wr_ok = !PROTECT_EN || DEBUG_ACCESS;
    ctrl_take = CTRL_WR && wr_ok && !state_r.busy;
    sync_done = state_r.busy && (state_r.busy_cnt == pinirq_pkg::SYNC_CYC - 3'h1);
    det_g = det[NL-1:0] & {NL{state_r.enable_act}};
    state_nxt.tick_prev = pins_s[NL+1];

    if (ctrl_take) begin
      state_nxt.busy = 1'b1;
      state_nxt.busy_cnt = 3'h0;
      if (CTRL_WDATA.soft_reset_bit) begin
        state_nxt.soft_reset_bit_pend = 1'b1;
      end else begin
        state_nxt.enable_r = CTRL_WDATA.enable;
      end
    end else if (state_r.busy) begin
      state_nxt.busy_cnt = state_r.busy_cnt + 3'h1;
    end

    for (int i = 0; i < NL; i++) begin
      if (CFG_WR[i] && wr_ok) begin
        state_nxt.cfg[i] = CFG_WDATA[i];
      end
    end
    if (NONMASK_CTRL_WR && wr_ok) begin
      state_nxt.nmi_cfg = NONMASK_CTRL_WDATA;
    end
    if (EVENT_OUT_CTRL_WR && wr_ok) begin
      state_nxt.evt_en = EVENT_OUT_CTRL_WDATA;
    end
    if (wr_ok) begin
      state_nxt.inten = (state_r.inten & ~IRQ_ENABLE_CLEAR) | IRQ_ENABLE_SET;
    end

    // A detection in the clearing cycle keeps the flag set
    state_nxt.flag = (state_r.flag & ~LINE_FLAG_CLR) | det_g;
    state_nxt.nmi_flag = (state_r.nmi_flag & ~NONMASK_FLAG_CLR) | det[NL];

    state_nxt.evt = det_g & ~state_r.det_prev & state_r.evt_en;
    state_nxt.det_prev = det_g;

    state_nxt.clk_req = pinirq_pkg::needs_sample_clk(state_r.nmi_cfg);
    for (int i = 0; i < NL; i++) begin
      if (state_r.enable_act && pinirq_pkg::needs_sample_clk(state_r.cfg[i])) begin
        state_nxt.clk_req = 1'b1;
      end
    end

    if (sync_done) begin
      state_nxt.busy = 1'b0;
      if (state_r.soft_reset_bit_pend) begin
        state_nxt = pinirq_pkg::STATE_RST;
        state_nxt.tick_prev = pins_s[NL+1];
      end else begin
        state_nxt.enable_act = state_r.enable_r;
      end
    end

    state_nxt.irq = state_nxt.flag & state_nxt.inten;
    state_nxt.nmi_irq = state_nxt.nmi_flag;
  end

  // No debug-halt input: the unit never freezes for a halted processor
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= pinirq_pkg::STATE_RST;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  assign SAMPLE_CLK_REQ = state_r.clk_req;
  assign CTRL_RD = '{enable: state_r.enable_r, soft_reset_bit: state_r.soft_reset_bit_pend};
  assign SYNC_BUSY = state_r.busy;
  assign CFG_RD = state_r.cfg;
  assign NONMASK_CTRL_RD = state_r.nmi_cfg;
  assign EVENT_OUT_CTRL_RD = state_r.evt_en;
  assign IRQ_ENABLE_RD = state_r.inten;
  assign LINE_FLAG_RD = state_r.flag;
  assign NONMASK_FLAG_RD = state_r.nmi_flag;
  assign LINE_IRQ = state_r.irq;
  assign NONMASK_IRQ = state_r.nmi_irq;
  assign LINE_EVENT = state_r.evt;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N || !CE);

  a_irq_flag_mask: assert property (
    LINE_IRQ == (LINE_FLAG_RD & IRQ_ENABLE_RD))
    else $error("line request differs from flag and enable");

  a_nmi_unmasked: assert property (
    NONMASK_IRQ == NONMASK_FLAG_RD)
    else $error("non-maskable request differs from its flag");

  a_busy_window: assert property (
    ctrl_take |=> SYNC_BUSY [*3] ##1 !SYNC_BUSY)
    else $error("sync busy not held for the sync delay");

  a_soft_reset_bit_wins: assert property (
    (ctrl_take && CTRL_WDATA.soft_reset_bit) |-> ##4 (CTRL_RD == '0 && IRQ_ENABLE_RD == '0
      && LINE_FLAG_RD == '0 && !state_r.enable_act))
    else $error("soft reset did not restore reset state");

  a_set_beats_clear: assert property (
    (det_g != '0 && !sync_done) |=> ((LINE_FLAG_RD & $past(det_g)) == $past(det_g)))
    else $error("detection lost against flag clear");

  a_disabled_quiet: assert property (
    !state_r.enable_act |=> (LINE_FLAG_RD & ~$past(LINE_FLAG_RD)) == '0)
    else $error("flag set while unit disabled");

  a_nmi_no_enable: assert property (
    (det[NL] && !sync_done) |=> NONMASK_FLAG_RD)
    else $error("non-maskable detection did not set flag");

  a_clk_request: assert property (
    (state_r.nmi_cfg.filt_en && state_r.nmi_cfg.sense != pinirq_pkg::SENSE_NONE
      && !sync_done) |=> SAMPLE_CLK_REQ)
    else $error("sampling clock not requested");

  a_event_single: assert property (
    (LINE_EVENT & ~$past(EVENT_OUT_CTRL_RD)) == '0 && (LINE_EVENT & $past(LINE_EVENT)) == '0)
    else $error("event without enable or held two cycles");

  a_level_latency: assert property (
    (state_r.enable_act && !state_r.busy && state_r.cfg[0].sense == pinirq_pkg::SENSE_HIGH
      && !state_r.cfg[0].filt_en && EXT_LINE[0]) [*3] |=> LINE_FLAG_RD[0])
    else $error("unfiltered level flag later than three cycles");

endmodule : pinirq_top

// File: hw/pinirq_pkg.sv
// Package for the external pin interrupt unit: sizes, sense codes, carriers.
// Assumes a single core clock; pins and the sampling clock arrive unsynchronised.
package pinirq_pkg;

  localparam int NUM_LINES = 16;
  localparam int SYNC_STAGES = 2;

  // Sense codes of a line or of the non-maskable line
  localparam logic [2:0] SENSE_NONE = 3'h0;
  localparam logic [2:0] SENSE_RISE = 3'h1;
  localparam logic [2:0] SENSE_FALL = 3'h2;
  localparam logic [2:0] SENSE_BOTH = 3'h3;
  localparam logic [2:0] SENSE_HIGH = 3'h4;
  localparam logic [2:0] SENSE_LOW = 3'h5;

  // Core cycles from a control write until enable or soft reset takes effect
  localparam logic [2:0] SYNC_CYC = 3'h3;

  typedef struct packed {
    logic filt_en;
    logic [2:0] sense;
  } pinirq_linecfg_t;

  typedef struct packed {
    logic enable;
    logic soft_reset_bit;
  } pinirq_ctrl_t;

  typedef struct packed {
    logic enable_r;
    logic enable_act;
    logic soft_reset_bit_pend;
    logic busy;
    logic [2:0] busy_cnt;
    pinirq_linecfg_t [NUM_LINES-1:0] cfg;
    pinirq_linecfg_t nmi_cfg;
    logic [NUM_LINES-1:0] evt_en;
    logic [NUM_LINES-1:0] inten;
    logic [NUM_LINES-1:0] flag;
    logic nmi_flag;
    logic [NUM_LINES-1:0] irq;
    logic nmi_irq;
    logic [NUM_LINES-1:0] evt;
    logic [NUM_LINES-1:0] det_prev;
    logic clk_req;
    logic tick_prev;
  } pinirq_state_t;

  localparam pinirq_linecfg_t LINECFG_RST = '0;
  localparam pinirq_state_t STATE_RST = '0;

  function automatic logic sense_is_edge(input logic [2:0] s);
    return (s == SENSE_RISE) || (s == SENSE_FALL) || (s == SENSE_BOTH);
  endfunction : sense_is_edge

  function automatic logic needs_sample_clk(input pinirq_linecfg_t c);
    return sense_is_edge(c.sense) || (c.filt_en && (c.sense != SENSE_NONE));
  endfunction : needs_sample_clk

endpackage : pinirq_pkg

// File: hw/pinirq_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
module pinirq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pinirq_sync_t;

  pinirq_sync_t state_r;
  pinirq_sync_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = din;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign dout = state_r.stable;

endmodule : pinirq_sync

// File: hw/pinirq_line.sv
// Detector for one line: sampler, majority filter, edge and level sense.
// Assumes pin is already synchronised and tick is a one-cycle sampling strobe.
module pinirq_line (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  input wire logic tick,
  input pinirq_pkg::pinirq_linecfg_t cfg,
  output logic det
);

  typedef struct packed {
    logic [2:0] smp;
    logic prev;
  } pinirq_line_t;

  pinirq_line_t state_r;
  pinirq_line_t state_nxt;
  logic maj;
  logic cur;
  logic level_val;

  always_comb begin
    maj = (state_r.smp[0] & state_r.smp[1]) | (state_r.smp[0] & state_r.smp[2])
      | (state_r.smp[1] & state_r.smp[2]);
    cur = cfg.filt_en ? maj : state_r.smp[0];
    // Unfiltered level reads the pin every core cycle, no sampling clock
    level_val = cfg.filt_en ? maj : pin;
    state_nxt = state_r;
    if (tick) begin
      state_nxt.smp = {state_r.smp[1:0], pin};
      state_nxt.prev = cur;
    end
    unique case (cfg.sense)
      pinirq_pkg::SENSE_RISE: det = tick & cur & ~state_r.prev;
      pinirq_pkg::SENSE_FALL: det = tick & ~cur & state_r.prev;
      pinirq_pkg::SENSE_BOTH: det = tick & (cur ^ state_r.prev);
      pinirq_pkg::SENSE_HIGH: det = level_val;
      pinirq_pkg::SENSE_LOW: det = ~level_val;
      default: det = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  a_majority_vote: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.filt_en && cfg.sense == pinirq_pkg::SENSE_HIGH)
      |-> det == ((state_r.smp[0] + state_r.smp[1] + state_r.smp[2]) >= 2'd2))
    else $error("filtered level does not follow two of three samples");

  a_level_async: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.filt_en && cfg.sense == pinirq_pkg::SENSE_LOW) |-> det == !pin)
    else $error("unfiltered low level does not follow pin");

  a_edge_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
    (pinirq_pkg::sense_is_edge(cfg.sense) && !tick) |-> !det)
    else $error("edge detection outside a sampling tick");

endmodule : pinirq_line

// File: testbench/pinirq_far_model.sv
// Far-side model: sampling clock source that answers the unit's clock request.
// Assumes the core clock runs at least eight times the sampling clock rate.
module pinirq_far_model #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_clk_req,
  output logic sample_clk
);
  int cnt;

  // Runs only on request; a started high phase is always completed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      sample_clk <= 1'b0;
    end else if (sample_clk_req || sample_clk) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        sample_clk <= !sample_clk;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : pinirq_far_model

// File: testbench/pinirq_top_bench.sv
// Bench for the pin interrupt unit: write tasks, pin stimulus, flag and request checks.
// Assumes the far-side model supplies the sampling clock whenever it is requested.
module pinirq_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4;
  localparam int SP = 2 * HALF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] ext_line = 16'h0000;
  logic nmi_pin = 1'b0;
  logic sclk;
  logic sclk_req;
  logic ctrl_wr = 1'b0;
  pinirq_pkg::pinirq_ctrl_t ctrl_wdata = '0;
  pinirq_pkg::pinirq_ctrl_t ctrl_rd;
  logic busy;
  logic [15:0] cfg_wr = 16'h0000;
  pinirq_pkg::pinirq_linecfg_t [15:0] cfg_wdata = '0;
  pinirq_pkg::pinirq_linecfg_t [15:0] cfg_rd;
  pinirq_pkg::pinirq_linecfg_t [15:0] exp_cfg;
  logic nm_wr = 1'b0;
  pinirq_pkg::pinirq_linecfg_t nm_wdata = '0;
  pinirq_pkg::pinirq_linecfg_t nm_rd;
  logic ev_wr = 1'b0;
  logic [15:0] ev_wdata = 16'h0000;
  logic [15:0] en_set = 16'h0000;
  logic [15:0] en_clr = 16'h0000;
  logic [15:0] flag_clr = 16'h0000;
  logic [15:0] ev_rd, en_rd, flag_rd, irq, evt;
  logic nm_clr = 1'b0;
  logic prot = 1'b0;
  logic dbg = 1'b0;
  logic nm_flag, nm_irq;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  pinirq_far_model #(.HALF(HALF)) u_pinirq_far_model (
    .clk(clk), .rst_n(rst_n), .sample_clk_req(sclk_req), .sample_clk(sclk)
  );

  pinirq_top u_pinirq_top (
    .CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1), .EXT_LINE(ext_line),
    .NONMASK_PIN(nmi_pin), .SAMPLE_CLK(sclk), .SAMPLE_CLK_REQ(sclk_req),
    .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata), .CTRL_RD(ctrl_rd), .SYNC_BUSY(busy),
    .CFG_WR(cfg_wr), .CFG_WDATA(cfg_wdata), .CFG_RD(cfg_rd),
    .NONMASK_CTRL_WR(nm_wr), .NONMASK_CTRL_WDATA(nm_wdata), .NONMASK_CTRL_RD(nm_rd),
    .EVENT_OUT_CTRL_WR(ev_wr), .EVENT_OUT_CTRL_WDATA(ev_wdata), .EVENT_OUT_CTRL_RD(ev_rd),
    .IRQ_ENABLE_SET(en_set), .IRQ_ENABLE_CLEAR(en_clr), .IRQ_ENABLE_RD(en_rd),
    .LINE_FLAG_CLR(flag_clr), .LINE_FLAG_RD(flag_rd), .NONMASK_FLAG_CLR(nm_clr),
    .NONMASK_FLAG_RD(nm_flag), .PROTECT_EN(prot), .DEBUG_ACCESS(dbg),
    .LINE_IRQ(irq), .NONMASK_IRQ(nm_irq), .LINE_EVENT(evt)
  );

  task automatic final_report();
    $display("Counts: %0d checked, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      $display("ERROR run time expected below 2000 cycles seen %0d", cycles);
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic strobe(ref logic [15:0] s, input logic [15:0] v);
    s = v;
    tick(1);
    s = 16'h0000;
    tick(1);
  endtask : strobe

  task automatic wr_cfg(input int i, input logic [3:0] v);
    cfg_wdata[i] = v;
    cfg_wr = 16'h0001 << i;
    tick(1);
    cfg_wr = 16'h0000;
    tick(1);
  endtask : wr_cfg

  task automatic ctrl_seq(input logic en, input logic sr, input logic [1:0] rd);
    ctrl_wdata = {en, sr};
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
    chk("busy set", 1, busy);
    chk("control readback", rd, ctrl_rd);
    tick(2);
    chk("busy held", 1, busy);
    tick(1);
    chk("busy done", 0, busy);
  endtask : ctrl_seq

  task automatic chk_idle();
    chk("config state", 0, cfg_rd);
    chk("other state", 0, {ctrl_rd, nm_rd, ev_rd, en_rd, flag_rd, nm_flag, busy});
  endtask : chk_idle

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    chk_idle();
    for (int i = 0; i < 16; i++) begin
      exp_cfg[i] = {i[0], 3'(i % 6)};
    end
    cfg_wdata = exp_cfg;
    strobe(cfg_wr, 16'hFFFF);
    chk("config readback", exp_cfg, cfg_rd);
    cfg_wdata = '0;
    strobe(cfg_wr, 16'hFFFF);
    $display("test reset and config done");

    ctrl_seq(1'b1, 1'b0, 2'b10);
    wr_cfg(0, {1'b0, pinirq_pkg::SENSE_HIGH});
    strobe(en_set, 16'h0001);
    ev_wdata = 16'h0001;
    ev_wr = 1'b1;
    tick(1);
    ev_wr = 1'b0;
    chk("event enable", 16'h0001, ev_rd);
    chk("irq enable", 16'h0001, en_rd);
    ext_line[0] = 1'b1;
    tick(3);
    chk("level flag", 1, flag_rd);
    chk("level irq", 1, irq);
    chk("level event", 1, evt);
    chk("no sample request", 0, sclk_req);
    tick(1);
    chk("event pulse end", 0, evt);
    strobe(flag_clr, 16'h0001);
    chk("level reassert", 1, flag_rd);
    strobe(en_clr, 16'h0001);
    tick(1);
    chk("masked irq", 0, irq);
    en_set = 16'h0001;
    en_clr = 16'h0001;
    tick(1);
    en_set = 16'h0000;
    en_clr = 16'h0000;
    tick(1);
    chk("set beats clear", 16'h0001, en_rd);
    chk("irq unmasked", 1, irq);
    ext_line[0] = 1'b0;
    tick(3);
    strobe(flag_clr, 16'h0001);
    chk("flag cleared", 0, flag_rd);
    tick(1);
    chk("irq dropped", 0, irq);
    $display("test level done");

    for (int i = 1; i < 6; i++) begin
      wr_cfg(i, {1'b0, 3'(i)});
    end
    tick(2);
    chk("sample request", 1, sclk_req);
    tick(4 * SP + 3);
    chk("idle flags", 16'h0020, flag_rd);
    ext_line[5:1] = 5'h1F;
    tick(4 * SP + 3);
    chk("rise flags", 16'h003A, flag_rd);
    strobe(flag_clr, 16'h0002);
    chk("partial clear", 16'h0038, flag_rd);
    strobe(flag_clr, 16'hFFFF);
    tick(4 * SP + 3);
    chk("rearm flags", 16'h0010, flag_rd);
    ext_line[5:1] = 5'h00;
    tick(4 * SP + 3);
    chk("fall flags", 16'h003C, flag_rd);
    cfg_wdata = '0;
    strobe(cfg_wr, 16'h003E);
    strobe(flag_clr, 16'hFFFF);
    $display("test edges done");

    wr_cfg(6, {1'b1, pinirq_pkg::SENSE_HIGH});
    wr_cfg(7, {1'b0, pinirq_pkg::SENSE_HIGH});
    tick(6 * SP);
    ext_line[7:6] = 2'b11;
    tick(3);
    ext_line[7:6] = 2'b00;
    tick(6 * SP + 3);
    chk("spike filtered", 16'h0080, flag_rd);
    ext_line[6] = 1'b1;
    tick(4 * SP + 3);
    chk("filtered level", 16'h00C0, flag_rd);
    ext_line[6] = 1'b0;
    $display("test filter done");

    ctrl_seq(1'b0, 1'b0, 2'b00);
    nm_wdata = {1'b0, pinirq_pkg::SENSE_HIGH};
    nm_wr = 1'b1;
    tick(1);
    nm_wr = 1'b0;
    chk("nmi config", nm_wdata, nm_rd);
    ext_line[0] = 1'b1;
    nmi_pin = 1'b1;
    strobe(flag_clr, 16'hFFFF);
    tick(3);
    chk("nmi flag", 1, nm_flag);
    chk("nmi irq", 1, nm_irq);
    chk("line gated", 0, flag_rd[0]);
    $display("test nmi done");

    prot = 1'b1;
    wr_cfg(8, {1'b0, pinirq_pkg::SENSE_RISE});
    chk("protected write", 0, cfg_rd[8]);
    nmi_pin = 1'b0;
    tick(3);
    nm_clr = 1'b1;
    tick(1);
    nm_clr = 1'b0;
    chk("nmi clear", 0, nm_flag);
    tick(1);
    chk("nmi irq drop", 0, nm_irq);
    dbg = 1'b1;
    wr_cfg(8, {1'b0, pinirq_pkg::SENSE_RISE});
    chk("debug write", {1'b0, pinirq_pkg::SENSE_RISE}, cfg_rd[8]);
    dbg = 1'b0;
    prot = 1'b0;
    $display("test protection done");

    strobe(en_set, 16'hFFFF);
    ctrl_seq(1'b1, 1'b1, 2'b01);
    chk_idle();
    $display("test soft reset done");
    final_report();
  end
endmodule : pinirq_top_bench
